/* rtl/pmwc_regs.svh */
// Register offsets, field positions, reset values and mode codes of the power-mode controller.
// Assumes a plain register port with byte addresses and 32-bit data.
// Contract
// - Five modes: Active, Sleep, Deep-sleep, Deep power-down, Battery-off
// - Battery-off left only by reset pin or tag
// - Active after reset; core runs only there
// - Sleep stops core clock until reset or interrupt
// - Sleep keeps masked peripheral clocks running
// - Sleep modes retain state, pins held static
// - Sleep wake keeps config; reset restores defaults
// - Deep-sleep gates core, powers analog down
// - Watchdog or timer may run in deep-sleep
// - Wake inputs: pins 0-10, tag, wake timer
// - Timer match wakes via enabled start input
// - Watchdog event or external reset wakes deep-sleep
// - Per-input programmable wake edge polarity
// - Deep-sleep exits on start logic interrupt
// - Edge-driven start logic; software clears first
// - Start logic gives interrupts in Active too
// - Tag data exchange only in Active mode
// - Debug unsupported in deep power-down
// - Analog blocks individually switchable any time
// - SPI and watchdog clocks with own dividers
// - Analog power bits 0,1,3,4,5; one means off
// - Status bits 10:0 pins, 11 tag, 12 timer
// - Writing one clears a start signal
`ifndef PMWC_REGS_SVH
`define PMWC_REGS_SVH
`define PMWC_ADDR_W 8
`define PMWC_OFS_PWR_CTRL 8'h00
`define PMWC_OFS_ANA_PD 8'h04
`define PMWC_OFS_BUS_CLK 8'h08
`define PMWC_OFS_CLK_SEL 8'h0c
`define PMWC_OFS_SYS_DIV 8'h10
`define PMWC_OFS_SPI_DIV 8'h14
`define PMWC_OFS_WDT_DIV 8'h18
`define PMWC_OFS_ST_EN 8'h1c
`define PMWC_OFS_ST_POL 8'h20
`define PMWC_OFS_ST_CLR 8'h24
`define PMWC_OFS_ST_STAT 8'h28
`define PMWC_OFS_MODE 8'h2c
`define PMWC_BIT_DPD_EN 0
`define PMWC_BIT_BATT_OFF 1
`define PMWC_ANA_W 6
`define PMWC_ANA_RST 6'h3a
`define PMWC_ANA_LIVE 6'h3b
`define PMWC_BUS_RST 32'h0000_001f
`define PMWC_DIV_RST 8'h01
`define PMWC_ST_W 13
`define PMWC_ST_TAG 11
`define PMWC_ST_TMR 12
`define PMWC_CODE_ACT 3'h0
`define PMWC_CODE_SLP 3'h1
`define PMWC_CODE_DSL 3'h2
`define PMWC_CODE_DPD 3'h3
`define PMWC_CODE_BOF 3'h4
`endif

/* rtl/pmwc_pkg.sv */
// Types shared by the power-mode controller.
// Assumes pmwc_regs.svh for widths.
`include "pmwc_regs.svh"
package pmwc_pkg;
  typedef struct packed {
    logic [`PMWC_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pmwc_bus_t;
  typedef enum logic [2:0] {
    PMWC_ACTIVE,
    PMWC_SLEEP,
    PMWC_DEEP_SLEEP,
    PMWC_DEEP_PD,
    PMWC_BATT_OFF
  } pmwc_mode_t;
endpackage

/* rtl/pmwc_top.sv */
// Power-mode controller with wake-up start logic and register port.
// Assumes one 100 MHz clock, synchronous reset and a core giving a
// wait-for-interrupt pulse, its deep-sleep select and its pending irq.
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`include "pmwc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pmwc_top
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire pmwc_pkg::pmwc_bus_t i_bus,
  output logic [31:0] o_rdata,
  // Core side
  input wire logic i_wait_for_interrupt_instr,
  input wire logic i_deep_sleep_select,
  input wire logic i_core_irq_pending,
  input wire logic i_watchdog_unit_event,
  // Wake pins and sources
  input wire logic [10:0] i_port_zero_pin,
  input wire logic i_tag_wake,
  input wire logic i_timer_wake,
  input wire logic i_external_reset_pin_n,
  // Mode and control outputs
  output logic [2:0] o_mode,
  output logic o_core_clk_en,
  output logic o_start_irq,
  output logic [`PMWC_ANA_W-1:0] o_analog_power_down_config,
  output logic [31:0] o_bus_clock_enable_mask,
  output logic [1:0] o_system_clock_frequency_select,
  output logic o_spi_clk_tick,
  output logic o_wdt_clk_tick,
  output logic o_hold_state,
  output logic o_tag_data_en,
  output logic o_debug_en
);
  import pmwc_pkg::*;

  localparam int SW = `PMWC_ST_W;
  localparam int PW = SW + 1;

  // Pin inputs through two flip-flops
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] meta_r;
  logic [PW-1:0] sync_r;
  logic [PW-1:0] meta_nxt;
  logic [PW-1:0] sync_nxt;
  logic [SW-1:0] prev_r;
  logic [SW-1:0] prev_nxt;

  assign pin_raw = {i_external_reset_pin_n, i_tag_wake, i_timer_wake,
                    i_port_zero_pin};

  always_comb
  begin
    meta_nxt = pin_raw;
    sync_nxt = meta_r;
    prev_nxt = sync_r[SW-1:0];
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  // Wake sources in status order: pins, tag, timer
  logic [SW-1:0] src_now;
  logic [SW-1:0] src_old;
  logic ext_rst_low;
  logic tag_sync;

  assign src_now = {sync_r[11], sync_r[12], sync_r[10:0]};
  assign src_old = {prev_r[11], prev_r[12], prev_r[10:0]};
  assign ext_rst_low = ~sync_r[PW-1];
  assign tag_sync = sync_r[12];

  // Software state
  logic [1:0] pwr_ctrl_r;
  logic [1:0] pwr_ctrl_nxt;
  logic [`PMWC_ANA_W-1:0] ana_r;
  logic [`PMWC_ANA_W-1:0] ana_nxt;
  logic [31:0] bus_clk_r;
  logic [31:0] bus_clk_nxt;
  logic [1:0] clk_sel_r;
  logic [1:0] clk_sel_nxt;
  logic [7:0] sys_div_r;
  logic [7:0] sys_div_nxt;
  logic [7:0] spi_div_r;
  logic [7:0] spi_div_nxt;
  logic [7:0] wdt_div_r;
  logic [7:0] wdt_div_nxt;
  logic [SW-1:0] st_en_r;
  logic [SW-1:0] st_en_nxt;
  logic [SW-1:0] st_pol_r;
  logic [SW-1:0] st_pol_nxt;
  logic [SW-1:0] st_stat_r;
  logic [SW-1:0] st_stat_nxt;
  logic [SW-1:0] st_hit;
  logic [SW-1:0] st_clr;
  logic [31:0] rdata_nxt;
  pmwc_mode_t mode_r;
  pmwc_mode_t mode_nxt;

  // Edge detect per start input, rising when polarity bit is one
  genvar g;
  generate
    for (g = 0; g < SW; g++)
    begin : g_start
      assign st_hit[g] = st_en_r[g] & (st_pol_r[g] ?
        (src_now[g] & ~src_old[g]) : (~src_now[g] & src_old[g]));
    end
  endgenerate

  // Write-one clear of latched start signals
  assign st_clr = (i_bus.wr && i_bus.addr == `PMWC_OFS_ST_CLR) ?
    i_bus.wdata[SW-1:0] : '0;

  // Mode code for reads and the mode output
  function automatic logic [2:0] mode_code(input pmwc_mode_t m);
    case (m)
      PMWC_ACTIVE: mode_code = `PMWC_CODE_ACT;
      PMWC_SLEEP: mode_code = `PMWC_CODE_SLP;
      PMWC_DEEP_SLEEP: mode_code = `PMWC_CODE_DSL;
      PMWC_DEEP_PD: mode_code = `PMWC_CODE_DPD;
      PMWC_BATT_OFF: mode_code = `PMWC_CODE_BOF;
      default: mode_code = `PMWC_CODE_ACT;
    endcase
  endfunction

  // Register writes, start status and read data
  always_comb
  begin
    pwr_ctrl_nxt = pwr_ctrl_r;
    ana_nxt = ana_r;
    bus_clk_nxt = bus_clk_r;
    clk_sel_nxt = clk_sel_r;
    sys_div_nxt = sys_div_r;
    spi_div_nxt = spi_div_r;
    wdt_div_nxt = wdt_div_r;
    st_en_nxt = st_en_r;
    st_pol_nxt = st_pol_r;
    // Set wins over a clear in the same cycle
    st_stat_nxt = (st_stat_r & ~st_clr) | st_hit;
    rdata_nxt = 32'h0000_0000;
    if (i_bus.wr)
    begin
      case (i_bus.addr)
        `PMWC_OFS_PWR_CTRL: pwr_ctrl_nxt = i_bus.wdata[1:0];
        `PMWC_OFS_ANA_PD: ana_nxt = i_bus.wdata[`PMWC_ANA_W-1:0] & `PMWC_ANA_LIVE;
        `PMWC_OFS_BUS_CLK: bus_clk_nxt = i_bus.wdata;
        `PMWC_OFS_CLK_SEL: clk_sel_nxt = i_bus.wdata[1:0];
        `PMWC_OFS_SYS_DIV: sys_div_nxt = i_bus.wdata[7:0];
        `PMWC_OFS_SPI_DIV: spi_div_nxt = i_bus.wdata[7:0];
        `PMWC_OFS_WDT_DIV: wdt_div_nxt = i_bus.wdata[7:0];
        `PMWC_OFS_ST_EN: st_en_nxt = i_bus.wdata[SW-1:0];
        `PMWC_OFS_ST_POL: st_pol_nxt = i_bus.wdata[SW-1:0];
        default: ;
      endcase
    end
    if (i_bus.rd)
    begin
      case (i_bus.addr)
        `PMWC_OFS_PWR_CTRL: rdata_nxt = {30'h0, pwr_ctrl_r};
        `PMWC_OFS_ANA_PD: rdata_nxt = {26'h0, ana_r};
        `PMWC_OFS_BUS_CLK: rdata_nxt = bus_clk_r;
        `PMWC_OFS_CLK_SEL: rdata_nxt = {30'h0, clk_sel_r};
        `PMWC_OFS_SYS_DIV: rdata_nxt = {24'h0, sys_div_r};
        `PMWC_OFS_SPI_DIV: rdata_nxt = {24'h0, spi_div_r};
        `PMWC_OFS_WDT_DIV: rdata_nxt = {24'h0, wdt_div_r};
        `PMWC_OFS_ST_EN: rdata_nxt = {19'h0, st_en_r};
        `PMWC_OFS_ST_POL: rdata_nxt = {19'h0, st_pol_r};
        `PMWC_OFS_ST_STAT: rdata_nxt = {19'h0, st_stat_r};
        `PMWC_OFS_MODE: rdata_nxt = {29'h0, mode_code(mode_r)};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      pwr_ctrl_r <= 2'h0;
      ana_r <= `PMWC_ANA_RST;
      bus_clk_r <= `PMWC_BUS_RST;
      clk_sel_r <= 2'h0;
      sys_div_r <= `PMWC_DIV_RST;
      spi_div_r <= 8'h00;
      wdt_div_r <= 8'h00;
      st_en_r <= '0;
      st_pol_r <= '0;
      st_stat_r <= '0;
      o_rdata <= 32'h0000_0000;
    end
    else
    begin
      pwr_ctrl_r <= pwr_ctrl_nxt;
      ana_r <= ana_nxt;
      bus_clk_r <= bus_clk_nxt;
      clk_sel_r <= clk_sel_nxt;
      sys_div_r <= sys_div_nxt;
      spi_div_r <= spi_div_nxt;
      wdt_div_r <= wdt_div_nxt;
      st_en_r <= st_en_nxt;
      st_pol_r <= st_pol_nxt;
      st_stat_r <= st_stat_nxt;
      o_rdata <= rdata_nxt;
    end
  end

  // Mode sequencing
  logic start_pend;
  assign start_pend = |st_stat_r;

  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      PMWC_ACTIVE:
      begin
        if (pwr_ctrl_r[`PMWC_BIT_BATT_OFF])
          mode_nxt = PMWC_BATT_OFF;
        else if (i_wait_for_interrupt_instr)
        begin
          if (pwr_ctrl_r[`PMWC_BIT_DPD_EN] && i_deep_sleep_select)
            mode_nxt = PMWC_DEEP_PD;
          else if (i_deep_sleep_select)
            mode_nxt = PMWC_DEEP_SLEEP;
          else if (!pwr_ctrl_r[`PMWC_BIT_DPD_EN])
            mode_nxt = PMWC_SLEEP;
        end
      end
      PMWC_SLEEP:
        if (i_core_irq_pending || start_pend)
          mode_nxt = PMWC_ACTIVE;
      PMWC_DEEP_SLEEP:
        if (start_pend || i_watchdog_unit_event || ext_rst_low)
          mode_nxt = PMWC_ACTIVE;
      PMWC_DEEP_PD:
        if (ext_rst_low)
          mode_nxt = PMWC_ACTIVE;
      PMWC_BATT_OFF:
        if (ext_rst_low || tag_sync)
          mode_nxt = PMWC_ACTIVE;
      default: mode_nxt = PMWC_ACTIVE;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      mode_r <= PMWC_ACTIVE;
    else
      mode_r <= mode_nxt;
  end

  // Peripheral clock dividers; zero shuts a clock off
  logic [7:0] spi_cnt_r;
  logic [7:0] spi_cnt_nxt;
  logic [7:0] wdt_cnt_r;
  logic [7:0] wdt_cnt_nxt;
  logic spi_tick_nxt;
  logic wdt_tick_nxt;
  logic wdt_run;

  // Watchdog keeps counting in deep-sleep while enabled
  assign wdt_run = (mode_nxt != PMWC_DEEP_PD) && (mode_nxt != PMWC_BATT_OFF);

  always_comb
  begin
    spi_cnt_nxt = 8'h00;
    spi_tick_nxt = 1'b0;
    wdt_cnt_nxt = 8'h00;
    wdt_tick_nxt = 1'b0;
    if (spi_div_r != 8'h00 && mode_nxt != PMWC_DEEP_SLEEP && wdt_run)
    begin
      spi_tick_nxt = (spi_cnt_r >= spi_div_r - 8'h01);
      spi_cnt_nxt = spi_tick_nxt ? 8'h00 : spi_cnt_r + 8'h01;
    end
    if (wdt_div_r != 8'h00 && wdt_run)
    begin
      wdt_tick_nxt = (wdt_cnt_r >= wdt_div_r - 8'h01);
      wdt_cnt_nxt = wdt_tick_nxt ? 8'h00 : wdt_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      spi_cnt_r <= 8'h00;
      wdt_cnt_r <= 8'h00;
      o_spi_clk_tick <= 1'b0;
      o_wdt_clk_tick <= 1'b0;
    end
    else
    begin
      spi_cnt_r <= spi_cnt_nxt;
      wdt_cnt_r <= wdt_cnt_nxt;
      o_spi_clk_tick <= spi_tick_nxt;
      o_wdt_clk_tick <= wdt_tick_nxt;
    end
  end

  // Registered outputs follow the next mode
  logic active_nxt;
  logic deep_nxt;
  logic [`PMWC_ANA_W-1:0] ana_out_nxt;
  logic [31:0] bus_out_nxt;

  assign active_nxt = (mode_nxt == PMWC_ACTIVE);
  assign deep_nxt = (mode_nxt == PMWC_DEEP_SLEEP) || (mode_nxt == PMWC_DEEP_PD);

  always_comb
  begin
    ana_out_nxt = ana_nxt;
    bus_out_nxt = bus_clk_nxt;
    if (deep_nxt)
      ana_out_nxt = `PMWC_ANA_LIVE;
    if (mode_nxt == PMWC_DEEP_PD || mode_nxt == PMWC_BATT_OFF)
      bus_out_nxt = 32'h0000_0000;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_mode <= `PMWC_CODE_ACT;
      o_core_clk_en <= 1'b1;
      o_start_irq <= 1'b0;
      o_analog_power_down_config <= `PMWC_ANA_RST;
      o_bus_clock_enable_mask <= `PMWC_BUS_RST;
      o_system_clock_frequency_select <= 2'h0;
      o_hold_state <= 1'b0;
      o_tag_data_en <= 1'b1;
      o_debug_en <= 1'b1;
    end
    else
    begin
      o_mode <= mode_code(mode_nxt);
      o_core_clk_en <= active_nxt;
      o_start_irq <= |st_stat_nxt;
      o_analog_power_down_config <= ana_out_nxt;
      o_bus_clock_enable_mask <= bus_out_nxt;
      o_system_clock_frequency_select <= clk_sel_nxt;
      o_hold_state <= (mode_nxt == PMWC_SLEEP) || (mode_nxt == PMWC_DEEP_SLEEP);
      o_tag_data_en <= active_nxt;
      o_debug_en <= (mode_nxt != PMWC_DEEP_PD);
    end
  end

endmodule
`default_nettype wire

/* testbench/pmwc_top_sva.sv */
// Port checker for the power-mode controller.
// Assumes it is bound to pmwc_top; one clock domain.
`include "pmwc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pmwc_top_sva
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Core side
  input wire logic i_wait_for_interrupt_instr,
  input wire logic i_deep_sleep_select,
  input wire logic i_core_irq_pending,
  input wire logic i_watchdog_unit_event,
  // Mode outputs
  input wire logic [2:0] o_mode,
  input wire logic o_core_clk_en,
  input wire logic o_hold_state,
  input wire logic o_tag_data_en,
  input wire logic o_debug_en,
  input wire logic [`PMWC_ANA_W-1:0] o_analog_power_down_config
);
  import pmwc_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // Wake and entry causes
  sequence sleep_wake_s;
    o_mode == `PMWC_CODE_SLP && i_core_irq_pending;
  endsequence
  sequence deep_wake_s;
    o_mode == `PMWC_CODE_DSL && i_watchdog_unit_event;
  endsequence
  sequence wfi_s;
    o_mode == `PMWC_CODE_ACT && i_wait_for_interrupt_instr;
  endsequence
  // Output relations and transitions
  core_clk_a: assert property (o_core_clk_en == (o_mode == `PMWC_CODE_ACT))
    else $error("core clock outside active");
  hold_pins_a: assert property (o_hold_state == (o_mode inside {`PMWC_CODE_SLP, `PMWC_CODE_DSL}))
    else $error("hold state wrong");
  tag_data_a: assert property (o_tag_data_en == (o_mode == `PMWC_CODE_ACT))
    else $error("tag data outside active");
  debug_off_a: assert property (o_debug_en == (o_mode != `PMWC_CODE_DPD))
    else $error("debug enable wrong");
  sleep_wake_a: assert property (sleep_wake_s |=> o_mode == `PMWC_CODE_ACT)
    else $error("no wake from sleep");
  deep_wake_a: assert property (deep_wake_s |=> o_mode == `PMWC_CODE_ACT)
    else $error("no watchdog wake");
  sleep_entry_a: assert property (wfi_s ##0 !i_deep_sleep_select |=> !(o_mode inside {2, 3}))
    else $error("deep mode without select");
  deep_entry_a: assert property (wfi_s ##0 i_deep_sleep_select |=> o_mode != `PMWC_CODE_SLP)
    else $error("sleep with select set");
  deep_analog_a: assert property (o_mode == `PMWC_CODE_DSL |-> o_analog_power_down_config == `PMWC_ANA_LIVE)
    else $error("analog not down in deep sleep");
endmodule
bind pmwc_top pmwc_top_sva chk_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_wait_for_interrupt_instr(i_wait_for_interrupt_instr), .i_deep_sleep_select(i_deep_sleep_select),
  .i_core_irq_pending(i_core_irq_pending), .i_watchdog_unit_event(i_watchdog_unit_event),
  .o_mode(o_mode), .o_core_clk_en(o_core_clk_en), .o_hold_state(o_hold_state),
  .o_tag_data_en(o_tag_data_en), .o_debug_en(o_debug_en),
  .o_analog_power_down_config(o_analog_power_down_config));
`default_nettype wire

/* testbench/pmwc_core_model.sv */
// Core model: wait-for-interrupt pulse, deep-sleep select, pending irq.
// Assumes the controller's mode code on i_mode.
`include "pmwc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pmwc_core_model
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Bench commands
  input wire logic i_sleep_req,
  input wire logic i_deep_req,
  input wire logic i_irq_req,
  input wire logic [1:0] i_irq_wait,
  // Controller side
  input wire logic [2:0] i_mode,
  output logic o_wfi,
  output logic o_sel,
  output logic o_irq
);
  logic [1:0] cnt_r;
  // Core steps; irq raised after a chosen delay
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_wfi <= 1'b0;
      o_sel <= 1'b0;
      o_irq <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      o_wfi <= i_sleep_req && i_mode == `PMWC_CODE_ACT;
      o_sel <= i_deep_req;
      cnt_r <= (i_irq_req && i_mode == `PMWC_CODE_SLP) ? cnt_r + 2'h1 : 2'h0;
      o_irq <= i_irq_req && i_mode == `PMWC_CODE_SLP && cnt_r >= i_irq_wait;
    end
  end
endmodule
`default_nettype wire

/* testbench/test_power_mode_wakeup_control.sv */
// Self-checking bench of the power-mode controller.
// Assumes pmwc_top, the core model and the bound checker.
`include "pmwc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_power_mode_wakeup_control;
  import pmwc_pkg::*;
  logic i_ref_clk, i_sys_rst, wait_for_interrupt_instr, sel, irq, wdog, tmr, sleep_req, deep_req, irq_req;
  logic clk_en, start_irq, hold, tag_en, dbg_en, spi_tick, wdt_tick;
  logic ext_rst_n, tag;
  pmwc_bus_t bus;
  logic [31:0] rdata, mask;
  logic [10:0] pins;
  logic [2:0] mode;
  logic [5:0] ana;
  logic [1:0] fsel;
  int n_errors = 0;
  int checks_done = 0;
  pmwc_top dut_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_bus(bus), .o_rdata(rdata),
    .i_wait_for_interrupt_instr(wait_for_interrupt_instr), .i_deep_sleep_select(sel), .i_core_irq_pending(irq),
    .i_watchdog_unit_event(wdog), .i_port_zero_pin(pins), .i_tag_wake(tag), .i_timer_wake(tmr),
    .i_external_reset_pin_n(ext_rst_n), .o_mode(mode), .o_core_clk_en(clk_en), .o_start_irq(start_irq),
    .o_analog_power_down_config(ana), .o_bus_clock_enable_mask(mask), .o_system_clock_frequency_select(fsel),
    .o_spi_clk_tick(spi_tick), .o_wdt_clk_tick(wdt_tick), .o_hold_state(hold), .o_tag_data_en(tag_en),
    .o_debug_en(dbg_en));
  pmwc_core_model core_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_sleep_req(sleep_req),
    .i_deep_req(deep_req), .i_irq_req(irq_req), .i_irq_wait(2'h2), .i_mode(mode), .o_wfi(wait_for_interrupt_instr),
    .o_sel(sel), .o_irq(irq));
  // Clock
  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_ref_clk);
    bus <= '0;
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_ref_clk);
    bus <= '0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic wait_mode(input logic [2:0] exp);
    int k;
    k = 0;
    while (mode !== exp && k < 20)
    begin
      @(posedge i_ref_clk);
      #1;
      k++;
    end
    chk({29'h0, mode}, {29'h0, exp});
  endtask
  // Count divider ticks over 30 cycles
  task automatic count_ticks(input logic [31:0] sn, input logic [31:0] wn);
    logic [31:0] a;
    logic [31:0] b;
    a = 32'h0;
    b = 32'h0;
    repeat (30)
    begin
      @(posedge i_ref_clk);
      #1;
      a = a + {31'h0, spi_tick};
      b = b + {31'h0, wdt_tick};
    end
    chk(a, sn);
    chk(b, wn);
  endtask
  task automatic enter(input logic d);
    @(posedge i_ref_clk);
    deep_req <= d;
    @(posedge i_ref_clk);
    sleep_req <= 1'b1;
    @(posedge i_ref_clk);
    sleep_req <= 1'b0;
  endtask
  task automatic do_reset;
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
  endtask
  task automatic results;
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #50000;
    n_errors++;
    $display("unexpected at %0t: run hung", $time);
    results;
  end
  // Test sequence
  initial
  begin
    bus = '0;
    pins = '0;
    {wdog, tmr, sleep_req, deep_req, irq_req} = '0;
    {ext_rst_n, tag} = 2'b10;
    do_reset;
    bus_rd(`PMWC_OFS_ANA_PD, {26'h0, `PMWC_ANA_RST});
    bus_rd(`PMWC_OFS_BUS_CLK, `PMWC_BUS_RST);
    bus_rd(`PMWC_OFS_MODE, 32'h0);
    bus_wr(`PMWC_OFS_ANA_PD, 32'h0000_003f);
    bus_rd(`PMWC_OFS_ANA_PD, 32'h0000_003b);
    bus_wr(`PMWC_OFS_ANA_PD, 32'h0000_0001);
    bus_rd(`PMWC_OFS_ANA_PD, 32'h0000_0001);
    bus_rd(8'h40, 32'h0);
    bus_wr(`PMWC_OFS_CLK_SEL, 32'h0000_0002);
    bus_rd(`PMWC_OFS_CLK_SEL, 32'h0000_0002);
    chk({30'h0, fsel}, 32'h0000_0002);
    count_ticks(32'h0, 32'h0);
    bus_wr(`PMWC_OFS_SPI_DIV, 32'h0000_0003);
    bus_wr(`PMWC_OFS_WDT_DIV, 32'h0000_0005);
    count_ticks(32'd10, 32'd6);
    $display("test registers done");
    bus_wr(`PMWC_OFS_ST_EN, 32'h0000_1001);
    bus_wr(`PMWC_OFS_ST_POL, 32'h0000_1001);
    bus_wr(`PMWC_OFS_ST_CLR, 32'h0000_1fff);
    tmr <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    #1 chk({31'h0, start_irq}, 32'h1);
    bus_rd(`PMWC_OFS_ST_STAT, 32'h0000_1000);
    bus_wr(`PMWC_OFS_ST_CLR, 32'h0000_1000);
    bus_rd(`PMWC_OFS_ST_STAT, 32'h0);
    $display("test active wake done");
    enter(1'b0);
    wait_mode(`PMWC_CODE_SLP);
    chk({30'h0, clk_en, hold}, 32'h1);
    chk(mask, `PMWC_BUS_RST);
    @(posedge i_ref_clk) irq_req <= 1'b1;
    wait_mode(`PMWC_CODE_ACT);
    @(posedge i_ref_clk) irq_req <= 1'b0;
    chk({26'h0, ana}, 32'h1);
    $display("test sleep done");
    enter(1'b1);
    wait_mode(`PMWC_CODE_DSL);
    chk({26'h0, ana}, {26'h0, `PMWC_ANA_LIVE});
    @(posedge i_ref_clk) pins[0] <= 1'b1;
    wait_mode(`PMWC_CODE_ACT);
    bus_rd(`PMWC_OFS_ST_STAT, 32'h1);
    bus_wr(`PMWC_OFS_ST_CLR, 32'h1);
    enter(1'b1);
    wait_mode(`PMWC_CODE_DSL);
    @(posedge i_ref_clk) wdog <= 1'b1;
    wait_mode(`PMWC_CODE_ACT);
    @(posedge i_ref_clk) wdog <= 1'b0;
    enter(1'b1);
    wait_mode(`PMWC_CODE_DSL);
    @(posedge i_ref_clk) ext_rst_n <= 1'b0;
    wait_mode(`PMWC_CODE_ACT);
    @(posedge i_ref_clk) ext_rst_n <= 1'b1;
    $display("test deep sleep done");
    bus_wr(`PMWC_OFS_PWR_CTRL, 32'h1);
    enter(1'b0);
    repeat (4) @(posedge i_ref_clk);
    wait_mode(`PMWC_CODE_ACT);
    enter(1'b1);
    wait_mode(`PMWC_CODE_DPD);
    chk({31'h0, dbg_en}, 32'h0);
    chk(mask, 32'h0);
    @(posedge i_ref_clk) ext_rst_n <= 1'b0;
    wait_mode(`PMWC_CODE_ACT);
    @(posedge i_ref_clk) ext_rst_n <= 1'b1;
    chk({31'h0, dbg_en}, 32'h1);
    bus_wr(`PMWC_OFS_PWR_CTRL, 32'h0000_0002);
    wait_mode(`PMWC_CODE_BOF);
    chk(mask, 32'h0);
    bus_wr(`PMWC_OFS_PWR_CTRL, 32'h0);
    repeat (8) @(posedge i_ref_clk);
    #1 chk({29'h0, mode}, {29'h0, `PMWC_CODE_BOF});
    @(posedge i_ref_clk) tag <= 1'b1;
    wait_mode(`PMWC_CODE_ACT);
    @(posedge i_ref_clk) tag <= 1'b0;
    do_reset;
    bus_rd(`PMWC_OFS_MODE, 32'h0);
    bus_rd(`PMWC_OFS_ANA_PD, {26'h0, `PMWC_ANA_RST});
    $display("test power-down done");
    results;
  end
endmodule
`default_nettype wire
